/* File: hdl/ovl_pkg.sv */
`default_nettype none
package ovl_pkg;
   // ======================================================
   // host port selector codes and internal register addresses
   localparam logic [1:0] SEL_ADDR = 2'h0;
   localparam logic [1:0] SEL_CRAM = 2'h1;
   localparam logic [1:0] SEL_REG = 2'h2;
   localparam logic [1:0] SEL_ORAM = 2'h3;
   localparam logic [7:0] ADDR_AND_FILTER = 8'h04;
   localparam logic [7:0] ADDR_BLINK_SELECT = 8'h05;
   localparam logic [7:0] ADDR_CONTROL = 8'h06;
   localparam logic [7:0] ADDR_READBACK = 8'h07;
   // ======================================================
   // overlay_blink_control fields
   localparam int CTL_P0_DISP = 0;
   localparam int CTL_P1_DISP = 1;
   localparam int CTL_P0_BLINK = 2;
   localparam int CTL_P1_BLINK = 3;
   localparam int CTL_RATE_LSB = 4;
   localparam int CTL_OVL0_EN = 6;
   // converter_input_readback fields
   localparam int TST_RED = 0;
   localparam int TST_GREEN = 1;
   localparam int TST_BLUE = 2;
   localparam int TST_HALF = 3;
   // ======================================================
   // blink on time and full period, in vertical retraces, per rate code
   localparam logic [7:0] BLINK_ON [0:3] = '{8'h10, 8'h10, 8'h20, 8'h40};
   localparam logic [7:0] BLINK_PERIOD [0:3] = '{8'h40, 8'h20, 8'h40, 8'h80};
   localparam int FIFO_DEPTH = 8;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [23:0] RGB_ZERO = 24'h000000;
   typedef enum logic [1:0] {PH_RED = 2'b00, PH_GREEN = 2'b01, PH_BLUE = 2'b10} rgb_phase_e;
   typedef struct packed {
      logic [7:0] index;
      logic [1:0] ovl;
      logic sync_n;
      logic blank_n;
   } pix_s;
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } rgb_s;
endpackage
`default_nettype wire

/* File: hdl/overlay_blink_mask_test_path.sv */
`default_nettype none
// ======================================================
// pixel word fifo
module pix_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic clk_in, // clock
   input wire logic rst_n_in, // async reset
   input wire logic in_valid_in, // push request
   input wire logic [WIDTH-1:0] in_data_in, // push data
   output logic in_ready_out, // not full
   output logic out_valid_out, // not empty
   output logic [WIDTH-1:0] out_data_out, // head word
   input wire logic out_ready_in // pop request
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   // full only at DEPTH words; the count is one bit wider than the pointers
   assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_out = (count_reg != '0);
   assign out_data_out = mem[rd_ptr_reg];
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data_in;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// Function
// (RQ1) plane zero blink enabled and off phase: plane zero overlay bits read zero.
// (RQ2) plane zero blinking acts only while plane zero display is enabled.
// (RQ3) plane one display off forces plane one overlay to zero, no blinking.
// (RQ4) plane zero display off forces plane zero overlay to zero, no blinking.
// (RQ5) every pixel index is ANDed with the and-filter register before lookup.
// (RQ6) all-ones filter passes index; a cleared filter bit forces that bit zero.
// (RQ7) and-filter register is host readable and writable at any time.
// (RQ8) blink-select bits make matching index bit planes blink at selected rate.
// (RQ9) rate code picks on/off retraces: 16/48, 16/16, 32/32, 64/64.
// (RQ10) plane one blink enabled and off phase zeroes plane one, if displayed.
// (RQ11) overlay code zero shows overlay entry zero unless entry-zero enable set.
// (RQ12) readback register upper nibble returns converter nibble; writes drop it.
// (RQ13) nibble half select: zero picks low nibble, one picks high nibble.
// (RQ14) readback bits 2,1,0 select blue, green, red; software sets only one.
// (RQ15) far side holds pixel inputs steady while the readback is accessed.
// (RQ16) readback register is host readable and writable at any time.
// (RQ17) each cycle every converter gets an 8-bit code from a palette.
// (RQ18) sync and blanking travel with their pixel to the converters.
// (RQ19) only green carries the sync offset; sync low removes it.
// (RQ20) blanking low drives all channels to blank level, data ignored.
// (RQ21) a nonzero overlay code selects overlay palette over colour palette.
// (RQ22) sync and blanking pipeline depth equals the pixel path latency.
module overlay_blink_mask_test_path (
   input wire logic ref_clk_in, // 50 MHz clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic host_cs_in, // host access strobe
   input wire logic host_wr_in, // 1 write, 0 read
   input wire logic [1:0] host_sel_in, // register selector
   input wire logic [7:0] host_data_in, // host write data
   output logic [7:0] host_data_out, // host read data
   output logic host_rd_valid_out, // read data valid pulse
   input wire logic vert_retrace_in, // one pulse per vertical retrace
   input wire logic pix_valid_in, // pixel word present
   input wire logic [7:0] pix_index_in, // colour palette index
   input wire logic overlay_plane_zero_in, // overlay bit 0
   input wire logic overlay_plane_one_in, // overlay bit 1
   input wire logic sync_n_in, // composite sync, active low
   input wire logic blank_n_in, // blanking, active low
   output logic pix_ready_out, // fifo can take a pixel
   input wire logic dac_ready_in, // converter side accepts data
   output logic dac_valid_out, // converter data valid
   output logic [7:0] red_out, // red code
   output logic [7:0] green_out, // green code
   output logic [7:0] blue_out, // blue code
   output logic green_sync_en_out, // sync offset on green
   output logic black_en_out // black offset on all channels
);
   // ======================================================
   // host registers
   logic [7:0] addr_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] and_filter_reg;
   logic [7:0] blink_sel_reg;
   logic [3:0] test_reg;
   ovl_pkg::rgb_phase_e phase_reg;
   ovl_pkg::rgb_phase_e phase_next;
   logic [15:0] rg_hold_reg;
   logic [23:0] cram [0:255];
   logic [23:0] oram [0:3];
   logic host_wr;
   logic host_rd;
   logic rgb_done;
   assign host_wr = host_cs_in && host_wr_in;
   assign host_rd = host_cs_in && !host_wr_in;
   assign rgb_done = host_wr && phase_reg == ovl_pkg::PH_BLUE
      && (host_sel_in == ovl_pkg::SEL_CRAM || host_sel_in == ovl_pkg::SEL_ORAM);

   always_comb
   begin
      phase_next = phase_reg;
      unique case (phase_reg)
         ovl_pkg::PH_RED: phase_next = ovl_pkg::PH_GREEN;
         ovl_pkg::PH_GREEN: phase_next = ovl_pkg::PH_BLUE;
         ovl_pkg::PH_BLUE: phase_next = ovl_pkg::PH_RED;
         default: phase_next = ovl_pkg::PH_RED;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         addr_reg <= ovl_pkg::REG_RESET;
         ctrl_reg <= ovl_pkg::REG_RESET;
         and_filter_reg <= ovl_pkg::REG_RESET;
         blink_sel_reg <= ovl_pkg::REG_RESET;
         test_reg <= ovl_pkg::REG_RESET[3:0];
         phase_reg <= ovl_pkg::PH_RED;
         rg_hold_reg <= ovl_pkg::RGB_ZERO[15:0];
      end
      else if (host_cs_in)
      begin
         if (host_sel_in == ovl_pkg::SEL_ADDR)
         begin
            phase_reg <= ovl_pkg::PH_RED;
            if (host_wr_in)
            begin
               addr_reg <= host_data_in;
            end
         end
         else if (host_sel_in == ovl_pkg::SEL_REG && host_wr_in)
         begin
            unique case (addr_reg)
               ovl_pkg::ADDR_AND_FILTER: and_filter_reg <= host_data_in; // [RQ7]
               ovl_pkg::ADDR_BLINK_SELECT: blink_sel_reg <= host_data_in;
               ovl_pkg::ADDR_CONTROL: ctrl_reg <= host_data_in;
               ovl_pkg::ADDR_READBACK: test_reg <= host_data_in[3:0]; // [RQ12] [RQ16]
               default: ;
            endcase
         end
         else if (host_wr_in && host_sel_in != ovl_pkg::SEL_REG)
         begin
            // palette words gather red, green, then commit on blue
            phase_reg <= phase_next;
            rg_hold_reg <= {rg_hold_reg[7:0], host_data_in};
            if (rgb_done)
            begin
               addr_reg <= addr_reg + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rgb_done && host_sel_in == ovl_pkg::SEL_CRAM)
      begin
         cram[addr_reg] <= {rg_hold_reg, host_data_in};
      end
      if (rgb_done && host_sel_in == ovl_pkg::SEL_ORAM)
      begin
         oram[addr_reg[1:0]] <= {rg_hold_reg, host_data_in};
      end
   end

   // ======================================================
   // blink timing over vertical retraces
   logic [7:0] blink_cnt_reg;
   logic [1:0] rate;
   logic blink_on;
   assign rate = ctrl_reg[ovl_pkg::CTL_RATE_LSB +: 2];
   assign blink_on = blink_cnt_reg < ovl_pkg::BLINK_ON[rate]; // [RQ9]
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         blink_cnt_reg <= ovl_pkg::REG_RESET;
      end
      else if (vert_retrace_in)
      begin
         // >= also recovers when a rate change shortens the period
         blink_cnt_reg <= (blink_cnt_reg + 8'h01 >= ovl_pkg::BLINK_PERIOD[rate])
            ? ovl_pkg::REG_RESET : blink_cnt_reg + 8'h01; // [RQ9]
      end
   end

   // ======================================================
   // pixel fifo
   ovl_pkg::pix_s fifo_in;
   ovl_pkg::pix_s fifo_head;
   logic fifo_valid;
   logic fifo_ready;
   logic advance;
   assign fifo_in = '{index: pix_index_in, ovl: {overlay_plane_one_in, overlay_plane_zero_in},
      sync_n: sync_n_in, blank_n: blank_n_in};
   // the whole path moves in lock step, so bubbles and stalls keep alignment
   assign advance = dac_ready_in; // [RQ22]
   pix_fifo #(.WIDTH($bits(ovl_pkg::pix_s)), .DEPTH(ovl_pkg::FIFO_DEPTH)) u_fifo (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(pix_valid_in),
      .in_data_in(fifo_in),
      .in_ready_out(fifo_ready),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_head),
      .out_ready_in(advance)
   );
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pix_ready_out <= 1'b0;
      end
      else
      begin
         pix_ready_out <= fifo_ready;
      end
   end

   // ======================================================
   // stage a: and-filter, bit plane blink, overlay gating
   ovl_pkg::pix_s a_reg;
   logic a_valid_reg;
   logic [7:0] index_gated;
   logic p0;
   logic p1;
   assign index_gated = fifo_head.index & and_filter_reg // [RQ5] [RQ6]
      & ~(blink_sel_reg & {8{~blink_on}}); // [RQ8]
   assign p0 = fifo_head.ovl[0] && ctrl_reg[ovl_pkg::CTL_P0_DISP] // [RQ4]
      && !(ctrl_reg[ovl_pkg::CTL_P0_BLINK] && !blink_on); // [RQ1] [RQ2]
   assign p1 = fifo_head.ovl[1] && ctrl_reg[ovl_pkg::CTL_P1_DISP] // [RQ3]
      && !(ctrl_reg[ovl_pkg::CTL_P1_BLINK] && !blink_on); // [RQ10]
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         a_valid_reg <= 1'b0;
         a_reg <= '0;
      end
      else if (advance)
      begin
         a_valid_reg <= fifo_valid;
         // an empty fifo shows a stale head; hold the last pixel for the readback
         if (fifo_valid)
         begin
            a_reg <= '{index: index_gated, ovl: {p1, p0},
               sync_n: fifo_head.sync_n, blank_n: fifo_head.blank_n}; // [RQ18]
         end
      end
   end

   // ======================================================
   // stage b: palette lookup and converter levels
   ovl_pkg::rgb_s pal_sel;
   logic [23:0] oram_word;
   assign oram_word = oram[a_reg.ovl];
   always_comb
   begin
      if (a_reg.ovl != 2'h0 || !ctrl_reg[ovl_pkg::CTL_OVL0_EN])
      begin
         pal_sel = oram_word; // [RQ21] [RQ11]
      end
      else
      begin
         pal_sel = cram[a_reg.index];
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dac_valid_out <= 1'b0;
         {red_out, green_out, blue_out} <= ovl_pkg::RGB_ZERO;
         green_sync_en_out <= 1'b0;
         black_en_out <= 1'b0;
      end
      else if (advance)
      begin
         dac_valid_out <= a_valid_reg;
         // blanked data is a don't-care; zero keeps the readback stable
         {red_out, green_out, blue_out} <= a_reg.blank_n ? pal_sel
            : ovl_pkg::RGB_ZERO; // [RQ17] [RQ20]
         green_sync_en_out <= a_reg.sync_n; // [RQ19]
         black_en_out <= a_reg.blank_n; // [RQ20]
      end
   end

   // ======================================================
   // host read data, including converter nibble readback
   logic [7:0] dac_pick;
   logic [3:0] nibble;
   always_comb
   begin
      dac_pick = 8'h00;
      if (test_reg[ovl_pkg::TST_RED])
      begin
         dac_pick = red_out; // [RQ14]
      end
      else if (test_reg[ovl_pkg::TST_GREEN])
      begin
         dac_pick = green_out;
      end
      else if (test_reg[ovl_pkg::TST_BLUE])
      begin
         dac_pick = blue_out;
      end
   end
   assign nibble = test_reg[ovl_pkg::TST_HALF] ? dac_pick[7:4] : dac_pick[3:0]; // [RQ13]
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         host_data_out <= ovl_pkg::REG_RESET;
         host_rd_valid_out <= 1'b0;
      end
      else
      begin
         host_rd_valid_out <= host_rd;
         if (host_rd)
         begin
            if (host_sel_in == ovl_pkg::SEL_ADDR)
            begin
               host_data_out <= addr_reg;
            end
            else if (host_sel_in != ovl_pkg::SEL_REG || addr_reg == ovl_pkg::ADDR_CONTROL)
            begin
               host_data_out <= (host_sel_in == ovl_pkg::SEL_REG) ? ctrl_reg : ovl_pkg::REG_RESET;
            end
            else if (addr_reg == ovl_pkg::ADDR_AND_FILTER)
            begin
               host_data_out <= and_filter_reg; // [RQ7]
            end
            else if (addr_reg == ovl_pkg::ADDR_BLINK_SELECT)
            begin
               host_data_out <= blink_sel_reg;
            end
            else if (addr_reg == ovl_pkg::ADDR_READBACK)
            begin
               host_data_out <= {nibble, test_reg}; // [RQ12] [RQ16]
            end
            else
            begin
               host_data_out <= ovl_pkg::REG_RESET;
            end
         end
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   logic take;
   assign take = advance && fifo_valid;
   a_filter_clears_bits: assert property (take // [RQ5] [RQ6]
      |=> (a_reg.index & ~$past(and_filter_reg)) == 8'h00)
      else $error("filtered index has bit outside and-filter");
   a_plane0_off_zero: assert property (take // [RQ4]
      && !ctrl_reg[ovl_pkg::CTL_P0_DISP] |=> !a_reg.ovl[0])
      else $error("plane zero passed while display disabled");
   a_plane1_off_zero: assert property (take // [RQ3]
      && !ctrl_reg[ovl_pkg::CTL_P1_DISP] |=> !a_reg.ovl[1])
      else $error("plane one passed while display disabled");
   a_plane0_blink_gap: assert property (take // [RQ1] [RQ2]
      && ctrl_reg[ovl_pkg::CTL_P0_BLINK] && !blink_on |=> !a_reg.ovl[0])
      else $error("plane zero shown in blink off phase");
   a_plane1_blink_gap: assert property (take // [RQ10]
      && ctrl_reg[ovl_pkg::CTL_P1_BLINK] && !blink_on |=> !a_reg.ovl[1])
      else $error("plane one shown in blink off phase");
   a_plane_blink_steady: assert property (take && blink_sel_reg == 8'h00 // [RQ8] [RQ6]
      && and_filter_reg == 8'hFF |=> a_reg.index == $past(fifo_head.index))
      else $error("unmasked steady index altered");
   a_overlay_wins: assert property (advance && a_reg.blank_n // [RQ21] [RQ17]
      && a_reg.ovl != 2'h0 |=> {red_out, green_out, blue_out} == $past(oram_word))
      else $error("nonzero overlay code did not pick overlay entry");
   a_entry_zero_sel: assert property (advance && a_reg.blank_n && a_reg.ovl == 2'h0 // [RQ11]
      && !ctrl_reg[ovl_pkg::CTL_OVL0_EN] |=> {red_out, green_out, blue_out} == $past(oram_word))
      else $error("overlay entry zero not shown");
   a_blank_level: assert property (dac_valid_out && !black_en_out // [RQ20]
      |-> {red_out, green_out, blue_out} == ovl_pkg::RGB_ZERO)
      else $error("blanked pixel carries data");
   // start from a real word: an empty fifo head is stale or unwritten
   a_sync_follows: assert property (take ##1 advance // [RQ18] [RQ19] [RQ22]
      |=> green_sync_en_out == $past(fifo_head.sync_n, 2))
      else $error("sync misaligned with pixel");
   // a rate change may leave the count high until the next retrace wraps it
   a_blink_in_range: assert property (vert_retrace_in ##1 $stable(rate) // [RQ9]
      |-> blink_cnt_reg < ovl_pkg::BLINK_PERIOD[rate])
      else $error("blink counter outside period");
   a_readback_low: assert property (host_rd && host_sel_in == ovl_pkg::SEL_REG // [RQ12] [RQ16]
      && addr_reg == ovl_pkg::ADDR_READBACK |=> host_data_out[3:0] == $past(test_reg))
      else $error("readback low nibble wrong");
   c_overlay_shown: cover property (advance && a_reg.ovl != 2'h0 && a_reg.blank_n);
   c_fifo_full: cover property (!pix_ready_out ##1 dac_ready_in);
   c_readback: cover property (host_rd_valid_out && test_reg[ovl_pkg::TST_GREEN]);
   c_blink_wrap: cover property (vert_retrace_in && blink_cnt_reg == 8'h00 ##1 blink_on);
endmodule
`default_nettype wire

/* File: testbench/pixel_source.sv */
`default_nettype none
// ======================================================
// graphics controller model: one pixel word per send cycle
module pixel_source (
   input wire logic clk_in, // bench clock
   input wire logic send_in, // present word at next falling edge
   input wire ovl_pkg::pix_s word_in, // word to present
   input wire logic stall_in, // hold off the converter side
   output logic valid_out, // pixel word present
   output ovl_pkg::pix_s pix_out, // pixel word
   output logic ready_out // converter side accepts
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      valid_out = 1'b0;
      pix_out = '0;
      ready_out = 1'b1;
   end
   // idle word is inverted so a stale word never passes for a fresh one
   always @(negedge clk_in)
   begin
      valid_out <= send_in;
      pix_out <= send_in ? word_in : ~pix_out;
      ready_out <= ~stall_in;
   end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] filt;
      logic [7:0] ctl;
      ovl_pkg::pix_s pix;
   } row_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs = 1'b0;
   logic wr = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [7:0] hdi = 8'h00;
   logic retrace = 1'b0;
   logic send = 1'b0;
   logic stall = 1'b0;
   ovl_pkg::pix_s word = '0;
   ovl_pkg::pix_s pix;
   ovl_pkg::rgb_s e;
   ovl_pkg::rgb_s last;
   logic [7:0] hdo, red, grn, blu, t, v;
   logic rdv, pvalid, pready, dready, dvalid, gsync, black;
   int num_errors = 0;
   int checked = 0;
   int n;
   int on_t [0:3] = '{16, 16, 32, 64};
   int off_t [0:3] = '{48, 16, 32, 64};
   // filter, control, index, {overlay, sync_n, blank_n}
   row_s rows [0:8] = '{28'hFF405A3, 28'h0F405A3, 28'hFF005A3, 28'hFF435A7, 28'hFF435AD,
      28'hFF425AF, 28'hFF415AB, 28'hFF4F5AE, 28'h0040A53};
   always #10 clk = ~clk;
   overlay_blink_mask_test_path overlay_blink_mask_test_path_inst (.ref_clk_in(clk),
      .rst_n_in(rst_n), .host_cs_in(cs), .host_wr_in(wr), .host_sel_in(sel),
      .host_data_in(hdi), .host_data_out(hdo), .host_rd_valid_out(rdv),
      .vert_retrace_in(retrace), .pix_valid_in(pvalid), .pix_index_in(pix.index),
      .overlay_plane_zero_in(pix.ovl[0]), .overlay_plane_one_in(pix.ovl[1]),
      .sync_n_in(pix.sync_n), .blank_n_in(pix.blank_n), .pix_ready_out(pready),
      .dac_ready_in(dready), .dac_valid_out(dvalid), .red_out(red), .green_out(grn),
      .blue_out(blu), .green_sync_en_out(gsync), .black_en_out(black));
   pixel_source pixel_source_inst (.clk_in(clk), .send_in(send), .word_in(word),
      .stall_in(stall), .valid_out(pvalid), .pix_out(pix), .ready_out(dready));
   // ======================================================
   // expectations
   function automatic ovl_pkg::rgb_s col(input logic [7:0] i);
      return {i, ~i, i ^ 8'h3C};
   endfunction
   function automatic ovl_pkg::rgb_s ovc(input logic [1:0] j);
      return {6'h28, j, 6'h2C, j, 6'h30, j};
   endfunction
   function automatic ovl_pkg::rgb_s exp_rgb(input row_s r, input logic on, input logic [7:0] bs);
      logic [7:0] i;
      logic [1:0] o;
      i = r.pix.index & r.filt;
      if (!on)
         i = i & ~bs;
      o[0] = r.pix.ovl[0] & r.ctl[0] & (on | ~r.ctl[2]);
      o[1] = r.pix.ovl[1] & r.ctl[1] & (on | ~r.ctl[3]);
      if (!r.pix.blank_n)
         return '0;
      if (o != 2'h0)
         return ovc(o);
      if (!r.ctl[6])
         return ovc(2'h0);
      return col(i);
   endfunction
   // ======================================================
   // reporting
   task automatic conclude;
      $display("checks %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic timeout(input string m);
      num_errors++;
      $display("wrong value at %0t: %s never answered", $time, m);
      conclude();
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] want, input string m);
      checked++;
      if (got !== want)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, want);
      end
   endtask
   // ======================================================
   // host port and pixel tasks
   task automatic host(input logic w, input logic [1:0] s, input logic [7:0] d);
      @(negedge clk);
      cs = 1'b1;
      wr = w;
      sel = s;
      hdi = d;
      @(negedge clk);
      cs = 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      host(1'b1, ovl_pkg::SEL_ADDR, a);
      host(1'b1, ovl_pkg::SEL_REG, d);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] want, input string m);
      host(1'b1, ovl_pkg::SEL_ADDR, a);
      host(1'b0, ovl_pkg::SEL_REG, 8'h00);
      n = 0;
      while (rdv !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 4)
         timeout("read");
      chk(hdo, want, m);
   endtask
   task automatic pulse(input int k);
      repeat (k)
      begin
         @(negedge clk);
         retrace = 1'b1;
         @(negedge clk);
         retrace = 1'b0;
      end
   endtask
   task automatic pix_chk(input row_s r, input logic on, input logic [7:0] bs);
      e = exp_rgb(r, on, bs);
      @(posedge clk);
      #1 send = 1'b1;
      word = r.pix;
      @(posedge clk);
      #1 send = 1'b0;
      n = 0;
      while (dvalid !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 8)
         timeout("pixel");
      chk(red, e.red, "red");
      chk(grn, e.green, "green");
      chk(blu, e.blue, "blue");
      chk({7'h00, gsync}, {7'h00, r.pix.sync_n}, "sync");
      chk({7'h00, black}, {7'h00, r.pix.blank_n}, "blank");
      last = e;
      repeat (3) @(negedge clk);
   endtask
   // ======================================================
   // main sequence
   initial
   begin
      repeat (2) @(negedge clk);
      chk({dvalid, pready, rdv, gsync, black, 3'h0}, 8'h00, "flags in reset");
      chk(red | grn | blu, 8'h00, "codes in reset");
      rst_n = 1'b1;
      $display("test reset done");
      host(1'b1, ovl_pkg::SEL_ADDR, 8'h00);
      for (int i = 0; i < 256; i++)
      begin
         e = col(8'(i));
         host(1'b1, ovl_pkg::SEL_CRAM, e.red);
         host(1'b1, ovl_pkg::SEL_CRAM, e.green);
         host(1'b1, ovl_pkg::SEL_CRAM, e.blue);
      end
      host(1'b1, ovl_pkg::SEL_ADDR, 8'h00);
      for (int j = 0; j < 4; j++)
      begin
         e = ovc(2'(j));
         host(1'b1, ovl_pkg::SEL_ORAM, e.red);
         host(1'b1, ovl_pkg::SEL_ORAM, e.green);
         host(1'b1, ovl_pkg::SEL_ORAM, e.blue);
      end
      for (int a = 4; a < 7; a++)
      begin
         wreg(8'(a), 8'hA5 ^ 8'(a));
         rreg(8'(a), 8'hA5 ^ 8'(a), "register");
      end
      wreg(8'h08, 8'h3C);
      rreg(8'h08, 8'h00, "unmapped");
      $display("test registers done");
      wreg(ovl_pkg::ADDR_BLINK_SELECT, 8'h00);
      foreach (rows[k])
      begin
         wreg(ovl_pkg::ADDR_AND_FILTER, rows[k].filt);
         wreg(ovl_pkg::ADDR_CONTROL, rows[k].ctl);
         pix_chk(rows[k], 1'b1, 8'h00);
      end
      $display("test rows done");
      wreg(ovl_pkg::ADDR_BLINK_SELECT, 8'h80);
      wreg(ovl_pkg::ADDR_AND_FILTER, 8'hFF);
      for (int c = 0; c < 4; c++)
      begin
         t = 8'h4F | 8'(c << 4);
         wreg(ovl_pkg::ADDR_CONTROL, t);
         pix_chk({8'hFF, t, 12'h81F}, 1'b1, 8'h80);
         pulse(on_t[c]);
         pix_chk({8'hFF, t, 12'h81F}, 1'b0, 8'h80);
         pulse(off_t[c] - 1);
         pix_chk({8'hFF, t, 12'h81F}, 1'b0, 8'h80);
         pulse(1);
         pix_chk({8'hFF, t, 12'h81F}, 1'b1, 8'h80);
      end
      $display("test blink done");
      for (int k = 0; k < 6; k++)
      begin
         t = (8'h01 << (k % 3)) | (k >= 3 ? 8'h08 : 8'h00) | 8'hF0;
         v = (k % 3 == 0) ? last.red : (k % 3 == 1) ? last.green : last.blue;
         v = {k >= 3 ? v[7:4] : v[3:0], t[3:0]};
         wreg(ovl_pkg::ADDR_READBACK, t);
         rreg(ovl_pkg::ADDR_READBACK, v, "readback");
      end
      $display("test readback done");
      stall = 1'b1;
      wreg(ovl_pkg::ADDR_CONTROL, 8'h40);
      wreg(ovl_pkg::ADDR_BLINK_SELECT, 8'h00);
      @(posedge clk);
      for (int k = 0; k < 10; k++)
      begin
         #1 send = 1'b1;
         word = {8'(k + 16), 4'h3};
         @(posedge clk);
      end
      #1 send = 1'b0;
      repeat (3) @(negedge clk);
      chk({7'h00, pready}, 8'h00, "fifo full flag");
      stall = 1'b0;
      n = 0;
      repeat (20)
      begin
         @(negedge clk);
         if (dvalid === 1'b1)
         begin
            e = col(8'(n + 16));
            chk(red, e.red, "drained word");
            n++;
         end
      end
      chk(8'(n), 8'h08, "drained count");
      chk({7'h00, pready}, 8'h01, "fifo ready again");
      $display("test fifo done");
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk({dvalid, pready, rdv, gsync, black, 3'h0}, 8'h00, "flags in second reset");
      rst_n = 1'b1;
      rreg(ovl_pkg::ADDR_AND_FILTER, ovl_pkg::REG_RESET, "filter after reset");
      $display("test second reset done");
      conclude();
   end
endmodule
`default_nettype wire
